// ===== src/parallel_port_pin_ownership.sv
// pin ownership and multiplexing for the parallel master/slave port
module parallel_port_pin_ownership
    import pin_mux_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         module_enable,
    input  wire port_mode_t   port_mode,
    input  wire addr_mux_t    address_multiplex_field,
    input  wire logic         wide_data_select,
    input  wire cs_function_t chip_select_function_field,
    input  wire logic [15:0]  address_pin_enable_bits,
    input  wire logic         read_strobe_output_enable,
    input  wire logic         write_strobe_output_enable,
    input  wire logic         cs_one_polarity,
    input  wire logic         cs_two_polarity,
    input  wire logic         read_polarity,
    input  wire logic         write_polarity,
    input  wire logic         latch_polarity,
    input  wire logic [15:0]  address_value,
    input  wire logic         address_phase,
    input  wire logic         latch_low_active,
    input  wire logic         latch_high_active,
    input  wire logic         cs_one_active,
    input  wire logic         cs_two_active,
    input  wire logic         read_active,
    input  wire logic         write_active,
    input  wire logic         read_not_write,
    input  wire logic [15:0]  data_value,
    input  wire logic         data_drive,
    input  wire logic [15:0]  port_address_pins_in,
    input  wire logic [15:0]  port_data_lines_in,
    input  wire logic         read_strobe_pin_in,
    input  wire logic         write_strobe_pin_in,
    output logic      [15:0]  port_address_pins_out,
    output logic      [15:0]  port_address_pins_oe,
    output logic      [15:0]  port_address_pins_owned,
    output logic      [15:0]  port_data_lines_out,
    output logic      [15:0]  port_data_lines_oe,
    output logic      [15:0]  port_data_lines_owned,
    output logic              read_strobe_pin_out,
    output logic              read_strobe_pin_oe,
    output logic              read_strobe_pin_owned,
    output logic              write_strobe_pin_out,
    output logic              write_strobe_pin_oe,
    output logic              write_strobe_pin_owned,
    output logic              slave_select,
    output logic              slave_read,
    output logic              slave_write,
    output logic      [1:0]   slave_address,
    output logic      [15:0]  slave_data_in
);

    typedef struct packed {
        logic [15:0] addr_out;
        logic [15:0] addr_oe;
        logic [15:0] addr_owned;
        logic [15:0] data_out;
        logic [15:0] data_oe;
        logic [15:0] data_owned;
        logic        rd_out;
        logic        rd_oe;
        logic        rd_owned;
        logic        wr_out;
        logic        wr_oe;
        logic        wr_owned;
        logic        sel;
        logic        rd_in;
        logic        wr_in;
        logic [1:0]  addr_in;
        logic [15:0] data_in;
        logic        armed;
    } pin_state_t;

    pin_state_t  state;
    pin_state_t  next_state;
    logic        master;
    logic        slave;
    logic [15:0] owned;
    logic [15:0] as_chip_select;
    logic [15:0] as_latch;
    logic [15:0] as_slave_input;
    logic [15:0] mux_address;

    address_pin_decode decode (
        .module_enable              (module_enable),
        .port_mode                  (port_mode),
        .address_multiplex_field    (address_multiplex_field),
        .chip_select_function_field (chip_select_function_field),
        .address_pin_enable_bits    (address_pin_enable_bits),
        .owned                      (owned),
        .as_chip_select             (as_chip_select),
        .as_latch                   (as_latch),
        .as_slave_input             (as_slave_input)
    );

    // next pin picture; every output is registered so the pads see no decode glitches
    always_comb begin
        master     = module_enable && is_master(port_mode);
        slave      = module_enable && !is_master(port_mode);
        next_state = state;
        next_state.armed = 1'b1;

        // address pin group: chip select, latch strobe or address bit per pin
        next_state.addr_owned = owned;
        for (int i = 0; i < 16; i++) begin
            if (as_latch[i]) begin
                next_state.addr_out[i] = drive_level(
                    (i == latch_high_index) ? latch_high_active : latch_low_active,
                    latch_polarity);
            end else if (as_chip_select[i]) begin
                next_state.addr_out[i] = drive_level(
                    (i == cs_two_index) ? cs_two_active : cs_one_active,
                    (i == cs_two_index) ? cs_two_polarity : cs_one_polarity);
            end else begin
                next_state.addr_out[i] = address_value[i] & owned[i];
            end
        end
        // slave pins on this group only listen
        next_state.addr_oe = owned & ~as_slave_input;

        // data lines: which are claimed
        if (master) begin
            if (wide_data_select || is_full_mux(address_multiplex_field)) begin
                next_state.data_owned = all_lines_mask;
            end else begin
                next_state.data_owned = low_byte_mask;
            end
        end else if (slave) begin
            next_state.data_owned = low_byte_mask;
        end else begin
            next_state.data_owned = reset_word;
        end

        // address phase places the multiplexed address on the data lines
        if (is_full_mux(address_multiplex_field)) begin
            mux_address = address_value;
        end else begin
            mux_address = {data_value[15:8], address_value[7:0]};
        end
        if (master && address_phase && address_multiplex_field != mux_none) begin
            next_state.data_out = mux_address & next_state.data_owned;
            next_state.data_oe  = next_state.data_owned;
        end else begin
            next_state.data_out = data_value & next_state.data_owned;
            next_state.data_oe  = data_drive ? next_state.data_owned : reset_word;
        end
        // an upper line claimed only for addressing carries no data
        if (master && !wide_data_select && !(address_phase &&
                is_full_mux(address_multiplex_field))) begin
            next_state.data_oe = next_state.data_oe & low_byte_mask;
        end

        // read and write strobe pins
        next_state.rd_owned = slave || (master && read_strobe_output_enable);
        next_state.wr_owned = slave || (master && write_strobe_output_enable);
        next_state.rd_oe    = master && read_strobe_output_enable;
        next_state.wr_oe    = master && write_strobe_output_enable;
        if (port_mode == mode_master_one) begin
            // combined direction line plus enable strobe
            next_state.rd_out = drive_level(read_not_write, read_polarity);
            next_state.wr_out = drive_level(read_active || write_active,
                                            write_polarity);
        end else begin
            next_state.rd_out = drive_level(read_active, read_polarity);
            next_state.wr_out = drive_level(write_active, write_polarity);
        end
        if (!next_state.rd_oe) begin
            next_state.rd_out = reset_bit;
        end
        if (!next_state.wr_oe) begin
            next_state.wr_out = reset_bit;
        end

        // slave side: host strobes decoded with the programmed polarities
        next_state.sel   = slave &&
            (port_address_pins_in[cs_one_index] == cs_one_polarity);
        next_state.rd_in = slave && (read_strobe_pin_in == read_polarity);
        next_state.wr_in = slave && (write_strobe_pin_in == write_polarity);
        if (slave && port_mode == mode_addressable_slave) begin
            next_state.addr_in = port_address_pins_in[1:0];
        end else begin
            next_state.addr_in = 2'h0;
        end
        // the captured word carries only lines the port owns, so gpio traffic never leaks in
        next_state.data_in = port_data_lines_in & next_state.data_owned;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign port_address_pins_out   = state.addr_out;
    assign port_address_pins_oe    = state.addr_oe;
    assign port_address_pins_owned = state.addr_owned;
    assign port_data_lines_out     = state.data_out;
    assign port_data_lines_oe      = state.data_oe;
    assign port_data_lines_owned   = state.data_owned;
    assign read_strobe_pin_out     = state.rd_out;
    assign read_strobe_pin_oe      = state.rd_oe;
    assign read_strobe_pin_owned   = state.rd_owned;
    assign write_strobe_pin_out    = state.wr_out;
    assign write_strobe_pin_oe     = state.wr_oe;
    assign write_strobe_pin_owned  = state.wr_owned;
    assign slave_select            = state.sel;
    assign slave_read              = state.rd_in;
    assign slave_write             = state.wr_in;
    assign slave_address           = state.addr_in;
    assign slave_data_in           = state.data_in;

    // checks: outputs at one edge follow the settings sampled at the edge before
    default clocking chk @(posedge clock);
    endclocking
    default disable iff (rst);

    disabled_release_a: assert property (
        state.armed && !$past(module_enable) |->
            state.addr_owned == 16'h0000 && state.data_owned == 16'h0000 &&
            !state.rd_owned && !state.wr_owned)
        else $error("pins still claimed while port disabled");

    partial_mux_a: assert property (
        state.armed && $past(master) && $past(address_multiplex_field) == mux_partial |->
            state.addr_owned[7:1] == 7'h00 && state.data_owned[7:0] == 8'hff &&
            state.addr_owned[0] == $past(address_pin_enable_bits[0]))
        else $error("partial multiplex pin picture wrong");

    full_mux_a: assert property (
        state.armed && $past(master) && is_full_mux($past(address_multiplex_field)) |->
            state.addr_owned[13:2] == 12'h000 && state.data_owned == 16'hffff)
        else $error("full multiplex pin picture wrong");

    narrow_data_a: assert property (
        state.armed && $past(master) && !$past(wide_data_select) &&
        $past(address_multiplex_field) == mux_none |->
            state.data_owned == 16'h00ff && state.data_oe[15:8] == 8'h00)
        else $error("narrow master claims upper data lines");

    slave_claim_a: assert property (
        state.armed && $past(slave) |->
            state.rd_owned && state.wr_owned && state.addr_owned[14] &&
            !state.addr_oe[14] && !state.rd_oe && !state.wr_oe)
        else $error("slave control pins not claimed as inputs");

    slave_polarity_a: assert property (
        state.armed && $past(slave) |->
            slave_read == ($past(read_strobe_pin_in) == $past(read_polarity)) &&
            slave_write == ($past(write_strobe_pin_in) == $past(write_polarity)))
        else $error("slave strobe polarity not applied");

    slave_narrow_a: assert property (
        state.armed && $past(slave) |->
            state.data_owned == 16'h00ff && state.data_in[15:8] == 8'h00)
        else $error("slave uses upper data lines");

    enable_bit_a: assert property (
        state.armed && $past(master) && $past(address_multiplex_field) == mux_none |->
            state.addr_owned == $past(address_pin_enable_bits))
        else $error("address pin ownership ignores enable bit");

    cs_two_a: assert property (
        state.armed && $past(master) && $past(address_pin_enable_bits[15]) &&
        $past(chip_select_function_field) == cs_both_select |->
            state.addr_out[15] == ($past(cs_two_active) ~^ $past(cs_two_polarity)))
        else $error("chip select 2 pin not driving select");

    cs_one_a: assert property (
        state.armed && $past(master) && $past(address_pin_enable_bits[14]) &&
        $past(chip_select_function_field) == cs_both_address |->
            state.addr_out[14] == $past(address_value[14]))
        else $error("chip select 1 pin not driving address 14");

    strobe_gate_a: assert property (
        state.armed && $past(master) && !$past(read_strobe_output_enable) |->
            !state.rd_owned && !state.rd_oe && !state.rd_out)
        else $error("read strobe drives while its enable is clear");

    legacy_address_a: assert property (
        state.armed && $past(slave) && $past(port_mode) == mode_legacy_slave |->
            state.addr_owned[1:0] == 2'h0 && slave_address == 2'h0)
        else $error("legacy slave claims address pins");

    master_full_c: cover property (state.armed && $past(master) && $past(address_phase) &&
        is_full_mux($past(address_multiplex_field)));
    addressable_slave_c: cover property (state.sel && slave_write && slave_address == 2'h3);
    wide_master_c: cover property (state.data_oe == 16'hffff && !$past(address_phase));

endmodule

// ===== src/pin_mux_pkg.sv
// constants, codes and shared decode helpers for the parallel port pin multiplexer
package pin_mux_pkg;

    // port mode field; addressable slave has a code of its own and differs from legacy only in addressing
    typedef enum logic [1:0] {
        mode_legacy_slave      = 2'h0,
        mode_addressable_slave = 2'h1,
        mode_master_two        = 2'h2,
        mode_master_one        = 2'h3
    } port_mode_t;

    // address multiplex field
    typedef enum logic [1:0] {
        mux_none     = 2'h0,
        mux_partial  = 2'h1,
        mux_full     = 2'h2,
        mux_full_alt = 2'h3
    } addr_mux_t;

    // chip select function field
    typedef enum logic [1:0] {
        cs_both_address = 2'h0,
        cs_two_only     = 2'h1,
        cs_both_select  = 2'h2,
        cs_reserved     = 2'h3
    } cs_function_t;

    // pin positions on the address pin group
    localparam int cs_two_index     = 15;
    localparam int cs_one_index     = 14;
    localparam int latch_high_index = 1;
    localparam int latch_low_index  = 0;

    // pin groups handed back or claimed by the mux, data width and port mode settings
    localparam logic [15:0] partial_release_mask = 16'h00fe;
    localparam logic [15:0] full_release_mask    = 16'h3ffc;
    localparam logic [15:0] slave_addr_mask      = 16'h0003;
    localparam logic [15:0] low_byte_mask        = 16'h00ff;
    localparam logic [15:0] all_lines_mask       = 16'hffff;

    // value of every pin control after reset: nothing claimed, nothing driven
    localparam logic [15:0] reset_word = 16'h0000;
    localparam logic        reset_bit  = 1'b0;

    function automatic logic is_master(input port_mode_t m);
        is_master = (m == mode_master_two) || (m == mode_master_one);
    endfunction

    function automatic logic is_full_mux(input addr_mux_t x);
        is_full_mux = (x == mux_full) || (x == mux_full_alt);
    endfunction

    // level on a pin for an internal active flag and its polarity bit (1 = active high)
    function automatic logic drive_level(input logic active, input logic polarity);
        drive_level = active ~^ polarity;
    endfunction

endpackage

// ===== src/address_pin_decode.sv
// decides the role of each of the sixteen address pins from mode and enable settings
module address_pin_decode
    import pin_mux_pkg::*;
(
    input  wire logic         module_enable,
    input  wire port_mode_t   port_mode,
    input  wire addr_mux_t    address_multiplex_field,
    input  wire cs_function_t chip_select_function_field,
    input  wire logic [15:0]  address_pin_enable_bits,
    output logic      [15:0]  owned,
    output logic      [15:0]  as_chip_select,
    output logic      [15:0]  as_latch,
    output logic      [15:0]  as_slave_input
);
    logic        master;
    logic [15:0] release_mask;

    // role decode; the pin enable bit gates every master role, slave pins are claimed outright
    always_comb begin
        master         = is_master(port_mode);
        release_mask   = reset_word;
        as_chip_select = reset_word;
        as_latch       = reset_word;
        as_slave_input = reset_word;
        owned          = reset_word;
        if (address_multiplex_field == mux_partial) begin
            release_mask              = partial_release_mask;
            as_latch[latch_low_index] = 1'b1;
        end else if (is_full_mux(address_multiplex_field)) begin
            release_mask               = full_release_mask;
            as_latch[latch_low_index]  = 1'b1;
            as_latch[latch_high_index] = 1'b1;
        end
        // reserved function code falls back to plain address use
        as_chip_select[cs_two_index] = (chip_select_function_field == cs_two_only) ||
                                       (chip_select_function_field == cs_both_select);
        as_chip_select[cs_one_index] = (chip_select_function_field == cs_both_select);
        if (module_enable && master) begin
            owned = address_pin_enable_bits & ~release_mask;
        end else if (module_enable) begin
            owned[cs_one_index] = 1'b1;
            as_slave_input[cs_one_index] = 1'b1;
            if (port_mode == mode_addressable_slave) begin
                owned          = owned | slave_addr_mask;
                as_slave_input = as_slave_input | slave_addr_mask;
            end
            as_chip_select = reset_word;
            as_latch       = reset_word;
        end
        if (!module_enable) begin
            as_chip_select = reset_word;
            as_latch       = reset_word;
        end
    end
endmodule

// ===== testbench/host_model.sv
// behavioural external host driving the slave side of the port pins
module host_model
(
    input  wire logic        select,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  data,
    input  wire logic        pol,
    output logic      [15:0] addr_pins,
    output logic      [15:0] data_pins,
    output logic             rd_pin,
    output logic             wr_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // host strobes follow the polarity that software set to match this host
    always_comb begin
        rd_pin    = rd ~^ pol;
        wr_pin    = wr ~^ pol;
        addr_pins = {1'b0, select ~^ pol, ~data[5:0], ~data[7:2], addr};
        // upper byte is never driven by the host: show a changing pattern, not a held value
        data_pins = {~data, data};
    end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the parallel port pin ownership block
module tb
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        en;
        port_mode_t  mode;
        addr_mux_t   mux;
        logic        wide;
        logic [15:0] enb;
        logic [1:0]  strobe_en;
        logic [6:0]  act;
        logic [15:0] e_addr_own;
        logic [15:0] e_data_own;
        logic [15:0] e_data_oe;
        logic [15:0] e_data_out;
        logic [1:0]  e_addr_low;
        logic [1:0]  e_strobes;
        logic [3:0]  e_strobe_ctl;
    } row_t;
    // act is {read, write, read_not_write, address phase, latch low, latch high, data drive}
    // e_strobe_ctl is {read owned, read oe, write owned, write oe}
    localparam row_t rows [12] = '{
        '{1'h1, mode_master_two, mux_none, 1'h0, 16'hffff, 2'h3, 7'h41,
            16'hffff, 16'h00ff, 16'h00ff, 16'h0078, 2'h2, 2'h2, 4'hf},
        '{1'h1, mode_master_one, mux_none, 1'h0, 16'hffff, 2'h3, 7'h20,
            16'hffff, 16'h00ff, 16'h0, 16'h0, 2'h2, 2'h1, 4'hf},
        '{1'h1, mode_master_one, mux_none, 1'h0, 16'hffff, 2'h3, 7'h50,
            16'hffff, 16'h00ff, 16'h0, 16'h0, 2'h2, 2'h3, 4'hf},
        '{1'h1, mode_master_two, mux_none, 1'h0, 16'hffff, 2'h0, 7'h60,
            16'hffff, 16'h00ff, 16'h0, 16'h0, 2'h2, 2'h0, 4'h0},
        '{1'h1, mode_master_two, mux_partial, 1'h0, 16'hffff, 2'h3, 7'h0c,
            16'hff01, 16'h00ff, 16'h00ff, 16'h0036, 2'h1, 2'h0, 4'hf},
        '{1'h1, mode_master_two, mux_full, 1'h0, 16'hffff, 2'h3, 7'h0e,
            16'hc003, 16'hffff, 16'hffff, 16'h1236, 2'h3, 2'h0, 4'hf},
        '{1'h1, mode_master_two, mux_full_alt, 1'h0, 16'hffff, 2'h3, 7'h0e,
            16'hc003, 16'hffff, 16'hffff, 16'h1236, 2'h3, 2'h0, 4'hf},
        '{1'h1, mode_master_two, mux_none, 1'h1, 16'h5a5a, 2'h3, 7'h01,
            16'h5a5a, 16'hffff, 16'hffff, 16'h5678, 2'h2, 2'h0, 4'hf},
        '{1'h1, mode_legacy_slave, mux_none, 1'h1, 16'hffff, 2'h3, 7'h00,
            16'h4000, 16'h00ff, 16'h0, 16'h0, 2'h0, 2'h0, 4'ha},
        '{1'h1, mode_addressable_slave, mux_none, 1'h1, 16'hffff, 2'h3, 7'h00,
            16'h4003, 16'h00ff, 16'h0, 16'h0, 2'h0, 2'h0, 4'ha},
        '{1'h0, mode_addressable_slave, mux_none, 1'h1, 16'hffff, 2'h3, 7'h00,
            16'h0, 16'h0, 16'h0, 16'h0, 2'h0, 2'h0, 4'h0},
        '{1'h0, mode_master_two, mux_full, 1'h1, 16'hffff, 2'h3, 7'h7f,
            16'h0, 16'h0, 16'h0, 16'h0, 2'h0, 2'h0, 4'h0}};
    localparam logic [1:0] cs_exp [8] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1, 2'h0, 2'h3};
    logic clock, rst, module_enable, wide_data_select, read_strobe_output_enable;
    logic write_strobe_output_enable, cs_one_polarity, cs_two_polarity, read_polarity;
    logic write_polarity, latch_polarity, address_phase, latch_low_active, latch_high_active;
    logic cs_one_active, cs_two_active, read_active, write_active, read_not_write, data_drive;
    logic read_strobe_pin_in, write_strobe_pin_in, read_strobe_pin_out, read_strobe_pin_oe;
    logic read_strobe_pin_owned, write_strobe_pin_out, write_strobe_pin_oe, write_strobe_pin_owned;
    logic slave_select, slave_read, slave_write, host_sel, host_rd, host_wr, host_pol;
    logic [1:0]   slave_address, host_addr;
    logic [7:0]   host_data;
    logic [15:0]  address_pin_enable_bits, address_value, data_value, port_address_pins_in;
    logic [15:0]  port_data_lines_in, port_address_pins_out, port_address_pins_oe;
    logic [15:0]  port_address_pins_owned, port_data_lines_out, port_data_lines_oe;
    logic [15:0]  port_data_lines_owned, slave_data_in;
    port_mode_t   port_mode;
    addr_mux_t    address_multiplex_field;
    cs_function_t chip_select_function_field;
    int           mismatches, num_checks, cycles;

    parallel_port_pin_ownership uut (.clock, .rst, .module_enable, .port_mode,
        .address_multiplex_field, .wide_data_select, .chip_select_function_field,
        .address_pin_enable_bits, .read_strobe_output_enable, .write_strobe_output_enable,
        .cs_one_polarity, .cs_two_polarity, .read_polarity, .write_polarity, .latch_polarity,
        .address_value, .address_phase, .latch_low_active, .latch_high_active, .cs_one_active,
        .cs_two_active, .read_active, .write_active, .read_not_write, .data_value, .data_drive,
        .port_address_pins_in, .port_data_lines_in, .read_strobe_pin_in, .write_strobe_pin_in,
        .port_address_pins_out, .port_address_pins_oe, .port_address_pins_owned,
        .port_data_lines_out, .port_data_lines_oe, .port_data_lines_owned, .read_strobe_pin_out,
        .read_strobe_pin_oe, .read_strobe_pin_owned, .write_strobe_pin_out, .write_strobe_pin_oe,
        .write_strobe_pin_owned, .slave_select, .slave_read, .slave_write, .slave_address,
        .slave_data_in);

    host_model host (.select(host_sel), .rd(host_rd), .wr(host_wr), .addr(host_addr),
        .data(host_data), .pol(host_pol), .addr_pins(port_address_pins_in),
        .data_pins(port_data_lines_in), .rd_pin(read_strobe_pin_in), .wr_pin(write_strobe_pin_in));

    always #2.5 clock = ~clock;

    // a hang is cut short well past the roughly 55 cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic apply_row(input row_t r);
        module_enable <= r.en;
        port_mode <= r.mode;
        address_multiplex_field <= r.mux;
        wide_data_select <= r.wide;
        address_pin_enable_bits <= r.enb;
        {read_strobe_output_enable, write_strobe_output_enable} <= r.strobe_en;
        {read_active, write_active, read_not_write, address_phase, latch_low_active,
            latch_high_active, data_drive} <= r.act;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        {clock, data_drive, cs_one_active, cs_two_active, host_sel, host_rd, host_wr} = '0;
        {cs_one_polarity, cs_two_polarity, read_polarity, write_polarity, latch_polarity} = '1;
        {host_pol, rst} = 2'h3;
        {mismatches, num_checks, cycles, host_addr, host_data} = '0;
        chip_select_function_field = cs_both_select;
        address_value = 16'h1236;
        data_value = 16'h5678;
        apply_row(rows[0]);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        check("owned during reset", port_address_pins_owned, 16'h0);
        // ordinary cases, one row per setting
        foreach (rows[i]) begin
            @(posedge clock);
            apply_row(rows[i]);
            @(posedge clock);
            #1;
            check("address owned", port_address_pins_owned, rows[i].e_addr_own);
            check("data owned", port_data_lines_owned, rows[i].e_data_own);
            check("data oe", port_data_lines_oe, rows[i].e_data_oe);
            check("address low", {14'h0, port_address_pins_out[1:0] & port_address_pins_oe[1:0]},
                {14'h0, rows[i].e_addr_low});
            check("strobes", {14'h0, read_strobe_pin_out, write_strobe_pin_out},
                {14'h0, rows[i].e_strobes});
            check("data out", port_data_lines_out & port_data_lines_oe,
                rows[i].e_data_out);
            check("strobe pins", {12'h0, read_strobe_pin_owned, read_strobe_pin_oe,
                write_strobe_pin_owned, write_strobe_pin_oe},
                {12'h0, rows[i].e_strobe_ctl});
        end
        // chip select pins give way to address bits by function code, under both polarities
        @(posedge clock);
        apply_row(rows[0]);
        {cs_one_active, cs_two_active} <= 2'h3;
        for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            chip_select_function_field <= cs_function_t'(c[1:0]);
            {cs_one_polarity, cs_two_polarity} <= {2{~c[2]}};
            address_value <= {c[2], c[2], 14'h0};
            @(posedge clock);
            #1;
            check("cs pins", {14'h0, port_address_pins_out[15:14]}, {14'h0, cs_exp[c]});
        end
        // slave strobes under both polarities, read then write
        @(posedge clock);
        apply_row(rows[9]);
        data_drive <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            {cs_one_polarity, read_polarity, write_polarity, host_pol} <= {4{p[1]}};
            {host_sel, host_rd, host_wr, host_addr, host_data} <= {1'b1, ~p[0], p[0], 10'h3c3};
            @(posedge clock);
            #1;
            check("slave select", {15'h0, slave_select}, 16'h1);
            check("slave strobes", {14'h0, slave_read, slave_write}, {14'h0, ~p[0], p[0]});
            check("slave address", {14'h0, slave_address}, 16'h3);
            check("slave data", slave_data_in, 16'h00c3);
            check("slave data oe", port_data_lines_oe, 16'h00ff);
            check("slave data out", port_data_lines_out, 16'h0078);
        end
        // reset in mid-run, off the clock edge, clears ownership at once
        #1;
        rst <= 1'b1;
        #1;
        check("owned after reset", port_address_pins_owned, 16'h0);
        @(posedge clock);
        rst <= 1'b0;
        #1;
        check("owned at release", port_address_pins_owned, 16'h0);
        // one edge later the slave claim must come back on its own
        @(posedge clock);
        #1;
        check("owned after release", port_address_pins_owned, 16'h4003);
        complete_run();
    end
endmodule
